/* logic/sra_adc_ctrl.v */
// digital control of a 12-bit sar converter: conversion timing,
// 3-wire serial readout and nap/sleep power states.
// assumes strobe and shift clock are asynchronous pins; analog result
// arrives on sar_code and is stable when conversion ends.
`timescale 1ns/1ps
`include "sra_consts.vh"
// Contract
// - strobe rise starts conversion timed internally; a rise in nap or sleep starts none; code starts one if a waking shift clock rise shares the cycle
// - serial output high-impedance whenever strobe is high
// - strobe fall enables output and shows msb at once
// - strobe fall puts sample-and-hold into sampling
// - each shift clock fall advances one of the remaining 11 bits
// - result is 12 bits, msb first to lsb last
// - after lsb every shift clock fall outputs zero
// - shifted bits belong to the conversion just finished
// - device naps by itself when conversion ends
// - two strobe pulses with static shift clock give nap
// - four strobe pulses with static shift clock give sleep
// - wake from nap gives accurate result within one conversion
// - one shift clock pulse wakes from nap or sleep
module sra_adc_ctrl (
    input wire core_clk,
    input wire rst_b,
    input wire convert_strobe,
    input wire shift_clk,
    input wire [`SRA_RESULT_BITS-1:0] sar_code,
    output reg serial_result_out,
    output reg serial_result_oe,
    output reg sample_mode,
    output reg converting,
    output reg result_latch,
    output reg bias_on,
    output reg ref_on,
    output reg nap_state,
    output reg sleep_state
);
    // counts held as integers, then cut to counter width on purpose
    localparam integer CONVERT_STROBE_CYCLES_INT = `SRA_CONVERT_STROBE_CYCLES;
    localparam integer NAP_PULSES_INT = `SRA_NAP_PULSES;
    localparam integer SLEEP_PULSES_INT = `SRA_SLEEP_PULSES;
    localparam [`SRA_CONVERT_STROBE_CNT_W-1:0] CONVERT_STROBE_CYCLES =
        CONVERT_STROBE_CYCLES_INT[`SRA_CONVERT_STROBE_CNT_W-1:0];
    localparam [`SRA_PULSE_CNT_W-1:0] NAP_PULSES =
        NAP_PULSES_INT[`SRA_PULSE_CNT_W-1:0];
    localparam [`SRA_PULSE_CNT_W-1:0] SLEEP_PULSES =
        SLEEP_PULSES_INT[`SRA_PULSE_CNT_W-1:0];

    // one-hot power states
    localparam [2:0] ST_ACTIVE = `SRA_PWR_ACTIVE;
    localparam [2:0] ST_NAP = `SRA_PWR_NAP;
    localparam [2:0] ST_SLEEP = `SRA_PWR_SLEEP;

    wire convert_strobe_level;
    wire convert_strobe_rise;
    wire convert_strobe_fall;
    wire sck_rise;
    wire sck_fall;
    wire shreg_bit;
    wire [`SRA_PULSE_CNT_W-1:0] pulse_next;
    wire start_now;
    wire shift_now;

    sra_sync_edge u_convert_strobe_sync (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .pin_in(convert_strobe),
        .level(convert_strobe_level),
        .rise(convert_strobe_rise),
        .fall(convert_strobe_fall)
    );

    // pins sampled at the core clock: each shift clock phase must last
    // longer than one core clock, else an edge can be lost
    sra_sync_edge u_sck_sync (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .pin_in(shift_clk),
        .level(),
        .rise(sck_rise),
        .fall(sck_fall)
    );

    reg [`SRA_CONVERT_STROBE_CNT_W-1:0] convert_strobe_cnt;
    reg [`SRA_PULSE_CNT_W-1:0] pulse_cnt;
    reg [2:0] pwr_state;
    reg [2:0] next_pwr_state;
    reg convert_strobe_done;
    reg reading;

    assign pulse_next = pulse_cnt + 1'b1;
    // a strobe rise in the cycle of the waking shift clock rise still
    // starts a conversion; the host may raise it just after the wake pulse
    assign start_now = convert_strobe_rise && next_pwr_state == ST_ACTIVE;
    // a shift clock fall that lands with the strobe fall still counts
    assign shift_now = sck_fall && !convert_strobe_level && (reading || convert_strobe_fall);

    // conversion timer; runs off the core clock, not the shift clock
    always @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            convert_strobe_cnt <= {`SRA_CONVERT_STROBE_CNT_W{1'b0}};
            converting <= 1'b0;
            convert_strobe_done <= 1'b0;
        end
        else
        begin
            convert_strobe_done <= 1'b0;
            // rise starts conversion; a rise refused in nap or
            // sleep only counts as a power pulse
            if (start_now)
            begin
                converting <= 1'b1;
                convert_strobe_cnt <= CONVERT_STROBE_CYCLES - 1'b1;
            end
            else if (converting)
            begin
                if (convert_strobe_cnt == {`SRA_CONVERT_STROBE_CNT_W{1'b0}})
                begin
                    converting <= 1'b0;
                    convert_strobe_done <= 1'b1;
                end
                else
                    convert_strobe_cnt <= convert_strobe_cnt - 1'b1;
            end
        end
    end

    // load this conversion's code, held until next
    always @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            result_latch <= 1'b0;
        end
        else
        begin
            result_latch <= convert_strobe_done;
        end
    end

    // pulses of the strobe counted while the shift clock stays static;
    // any shift clock edge breaks the run, and the count stops at four
    always @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pulse_cnt <= {`SRA_PULSE_CNT_W{1'b0}};
        end
        else if (sck_rise || sck_fall)
        begin
            pulse_cnt <= {`SRA_PULSE_CNT_W{1'b0}};
        end
        else if (convert_strobe_rise && pulse_cnt != SLEEP_PULSES)
        begin
            pulse_cnt <= pulse_next;
        end
    end

    always @*
    begin
        next_pwr_state = pwr_state;
        case (pwr_state)
            ST_ACTIVE:
            begin
                if (convert_strobe_done)
                begin
                    next_pwr_state = ST_NAP;
                end
                else if (convert_strobe_rise && pulse_next == NAP_PULSES)
                begin
                    next_pwr_state = ST_NAP;
                end
            end
            ST_NAP:
            begin
                if (sck_rise)
                begin
                    next_pwr_state = ST_ACTIVE;
                end
                else if (convert_strobe_rise && pulse_next == SLEEP_PULSES)
                begin
                    next_pwr_state = ST_SLEEP;
                end
            end
            ST_SLEEP:
            begin
                // shift clock wakes; reference needs time to recover
                if (sck_rise)
                begin
                    next_pwr_state = ST_ACTIVE;
                end
            end
            default:
            begin
                next_pwr_state = ST_ACTIVE;
            end
        endcase
    end

    always @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pwr_state <= ST_ACTIVE;
        end
        else
        begin
            pwr_state <= next_pwr_state;
        end
    end

    // reference stays up in nap; only sleep drops it
    always @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            bias_on <= 1'b1;
            ref_on <= 1'b1;
            nap_state <= 1'b0;
            sleep_state <= 1'b0;
        end
        else
        begin
            case (next_pwr_state)
                ST_NAP:
                begin
                    bias_on <= 1'b1;
                    ref_on <= 1'b1;
                    nap_state <= 1'b1;
                    sleep_state <= 1'b0;
                end
                ST_SLEEP:
                begin
                    bias_on <= 1'b0;
                    ref_on <= 1'b0;
                    nap_state <= 1'b0;
                    sleep_state <= 1'b1;
                end
                default:
                begin
                    bias_on <= 1'b1;
                    ref_on <= 1'b1;
                    nap_state <= 1'b0;
                    sleep_state <= 1'b0;
                end
            endcase
        end
    end

    // readout window opens on strobe fall, closes on strobe rise
    always @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            reading <= 1'b0;
        end
        else if (convert_strobe_rise)
        begin
            reading <= 1'b0;
        end
        else if (convert_strobe_fall)
        begin
            reading <= 1'b1;
        end
    end

    // advance on shift clock fall during readout
    sra_shift_out u_shift (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .load(result_latch),
        .load_data(sar_code),
        .shift(shift_now),
        .bit_out(shreg_bit)
    );

    always @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            serial_result_out <= 1'b0;
            serial_result_oe <= 1'b0;
            sample_mode <= 1'b1;
        end
        else
        begin
            serial_result_oe <= !convert_strobe_level;
            // held low while floating so no stale bit shows
            serial_result_out <= convert_strobe_level ? 1'b0 : shreg_bit;
            sample_mode <= !convert_strobe_level;
        end
    end
endmodule

/* pkg/sra_consts.vh */
// timing and format constants for the serial sar readout block
// assumes a 40 MHz core clock; included by bare name
`ifndef SRA_CONSTS_VH
`define SRA_CONSTS_VH
`define SRA_CLK_PERIOD_PS 25000
`define SRA_RESULT_BITS 12
`define SRA_BIT_CNT_W 4
`define SRA_CONVERT_STROBE_TIME_PS 1400000
// least time, rounded up
`define SRA_CONVERT_STROBE_CYCLES ((`SRA_CONVERT_STROBE_TIME_PS + `SRA_CLK_PERIOD_PS - 1) / `SRA_CLK_PERIOD_PS)
`define SRA_CONVERT_STROBE_CNT_W 7
`define SRA_NAP_PULSES 2
`define SRA_SLEEP_PULSES 4
`define SRA_PULSE_CNT_W 3
`define SRA_PWR_ACTIVE 3'h1
`define SRA_PWR_NAP 3'h2
`define SRA_PWR_SLEEP 3'h4
`endif

/* logic/sra_sync_edge.v */
// two-flop synchroniser with edge detect on the second flop's output
// assumes the input comes from outside the core clock domain
`timescale 1ns/1ps
`include "sra_consts.vh"
module sra_sync_edge (
    input wire core_clk,
    input wire rst_b,
    input wire pin_in,
    output wire level,
    output wire rise,
    output wire fall
);
    reg meta;
    reg sync;
    reg prev;
    always @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            meta <= 1'b0;
            sync <= 1'b0;
            prev <= 1'b0;
        end
        else
        begin
            meta <= pin_in;
            sync <= meta;
            prev <= sync;
        end
    end
    assign level = sync;
    assign rise = sync & ~prev;
    assign fall = ~sync & prev;
endmodule

/* logic/sra_shift_out.v */
// 12-bit result shift register, msb first, zero fill after lsb
// load and shift are one-cycle pulses on the core clock
`timescale 1ns/1ps
`include "sra_consts.vh"
module sra_shift_out (
    input wire core_clk,
    input wire rst_b,
    input wire load,
    input wire [`SRA_RESULT_BITS-1:0] load_data,
    input wire shift,
    output wire bit_out
);
    reg [`SRA_RESULT_BITS-1:0] shreg;
    always @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            shreg <= {`SRA_RESULT_BITS{1'b0}};
        else if (load)
            shreg <= load_data;
        else if (shift)
            shreg <= {shreg[`SRA_RESULT_BITS-2:0], 1'b0};
    end
    assign bit_out = shreg[`SRA_RESULT_BITS-1];
endmodule

/* tb/sra_adc_ctrl_asserts.sv */
// port assertions for sra_adc_ctrl
// bound to the design; one core clock domain
`timescale 1ns/1ps
module sra_adc_ctrl_asserts (
    input wire core_clk,
    input wire rst_b,
    input wire convert_strobe,
    input wire shift_clk,
    input wire serial_result_oe,
    input wire sample_mode,
    input wire converting,
    input wire result_latch,
    input wire bias_on,
    input wire ref_on,
    input wire nap_state,
    input wire sleep_state
);
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);
    hiz_hold_a:
    assert property (convert_strobe [*4] |-> !serial_result_oe)
    else $error("oe on");
    out_enable_a:
    assert property ($fell(convert_strobe) ##1 !convert_strobe [*4]
        |-> serial_result_oe) else $error("oe off");
    sample_on_a:
    assert property ($fell(convert_strobe) ##1 !convert_strobe [*4]
        |-> sample_mode) else $error("hold");
    convert_strobe_len_a:
    assert property ($rose(converting) |-> converting [*8] ##48
        converting ##1 !converting) else $error("length");
    latch_pulse_a:
    assert property ($fell(converting) |-> ##1 result_latch ##1
        !result_latch) else $error("latch");
    self_nap_a:
    assert property ($fell(converting) |-> ##[0:2] nap_state) else $error("n");
    nap_ref_a:
    assert property (nap_state [*2] |-> bias_on && ref_on) else $error("ref");
    sleep_off_a:
    assert property (sleep_state [*2] |-> !bias_on && !ref_on) else $error("b");
    wake_up_a:
    assert property ($rose(shift_clk) && (nap_state || sleep_state)
        |-> ##[1:6] !nap_state && !sleep_state) else $error("asleep");
    cover property ($rose(sleep_state));
    cover property ($rose(serial_result_oe));
    cover property ($fell(converting) ##[1:3] nap_state);
endmodule
bind sra_adc_ctrl sra_adc_ctrl_asserts i_chk (.core_clk(core_clk),
    .rst_b(rst_b), .convert_strobe(convert_strobe), .shift_clk(shift_clk),
    .serial_result_oe(serial_result_oe), .sample_mode(sample_mode),
    .converting(converting), .result_latch(result_latch),
    .bias_on(bias_on), .ref_on(ref_on),
    .nap_state(nap_state), .sleep_state(sleep_state));

/* tb/sra_host.sv */
// host model: strobe, shift clock, serial capture
// paced by core_clk falling edges
`timescale 1ns/1ps
module sra_host (
    input wire core_clk,
    input wire serial_result_out,
    input wire serial_result_oe,
    output reg convert_strobe = 1'b0,
    output reg shift_clk = 1'b0
);
    task hold(input s, input k, input integer n);
    begin
        convert_strobe = s;
        shift_clk = k;
        repeat (n) @(negedge core_clk);
        shift_clk = 1'b0;
        repeat (n) @(negedge core_clk);
    end
    endtask
    // 200 ns shift period; sample late in the low phase
    task shift_out(output [14:0] w, output en);
        integer i;
    begin
        en = serial_result_oe;
        for (i = 14; i >= 0; i = i - 1)
        begin
            w[i] = serial_result_out;
            hold(1'b0, 1'b1, 4);
        end
    end
    endtask
endmodule

/* tb/test_sra_adc_ctrl.sv */
// self-checking bench for sra_adc_ctrl
// host model drives the pins, bench drives sar_code
`timescale 1ns/1ps
module test_sra_adc_ctrl;
    reg core_clk = 1'b0, rst_b = 1'b0, en;
    reg [11:0] sar_code = 12'h000;
    reg [14:0] w;
    wire convert_strobe, shift_clk, serial_result_out, serial_result_oe;
    wire [3:0] pwr;
    integer fails = 0, checks = 0, n;
    sra_adc_ctrl i_dut (.core_clk(core_clk), .rst_b(rst_b),
        .convert_strobe(convert_strobe), .shift_clk(shift_clk),
        .sar_code(sar_code), .serial_result_out(serial_result_out),
        .serial_result_oe(serial_result_oe), .sample_mode(), .converting(),
        .result_latch(), .bias_on(pwr[1]), .ref_on(pwr[0]),
        .nap_state(pwr[2]), .sleep_state(pwr[3]));
    sra_host i_host (.core_clk(core_clk), .convert_strobe(convert_strobe),
        .shift_clk(shift_clk), .serial_result_out(serial_result_out),
        .serial_result_oe(serial_result_oe));
    initial forever #12.5 core_clk = ~core_clk;
    function [14:0] line_word(input [11:0] c);
        line_word = {c, 3'h0};
    endfunction
    task check(input [63:0] s, input [14:0] e, input [14:0] g);
    begin
        checks = checks + 1;
        fails = fails + (g !== e);
        if (g !== e) $display("CHECK FAILED %0s exp %h got %h", s, e, g);
    end
    endtask
    task summarize;
    begin
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    end
    endtask
    // input flips after capture so a late grab shows
    task convert(input [11:0] c);
    begin
        sar_code = c;
        i_host.hold(1'b1, 1'b0, 35);
        i_host.hold(1'b0, 1'b0, 10);
        sar_code = ~c;
        i_host.shift_out(w, en);
        check("word", line_word(c), w);
        check("oe", 15'h1, {14'h0, en});
    end
    endtask
    initial
    begin
        n = $urandom(65664);
        repeat (5) @(negedge core_clk);
        rst_b = 1'b1;
        for (n = 0; n < 12; n = n + 1)
            convert(n < 2 ? {12{n[0]}} : 12'($urandom));
        for (n = 1; n < 5; n = n + 1)
        begin
            i_host.hold(1'b1, 1'b0, 35);
            i_host.hold(1'b0, 1'b0, 10);
            if (n == 2)
                check("nap", 15'h7, {11'h0, pwr});
        end
        check("sleep", 15'h8, {11'h0, pwr});
        i_host.hold(1'b0, 1'b1, 4);
        i_host.hold(1'b0, 1'b0, 22000);
        check("wake", 15'h3, {11'h0, pwr});
        convert(12'($urandom));
        i_host.hold(1'b1, 1'b0, 35);
        i_host.hold(1'b0, 1'b0, 10);
        check("auto nap", 15'h7, {11'h0, pwr});
        i_host.hold(1'b0, 1'b1, 4);
        check("nap wake", 15'h3, {11'h0, pwr});
        convert(12'($urandom));
        summarize;
    end
endmodule
